// >>> rtl/atbc_pkg.sv
package atbc_pkg;

   // wait-state targets, counted in processor clock cycles
   localparam logic [3:0] ATBC_WS_16BIT_MIN = 4'h1;
   localparam logic [3:0] ATBC_WS_8BIT_FIRST = 4'h3;
   localparam logic [3:0] ATBC_WS_8BIT_MIN = 4'h4;
   localparam logic [3:0] ATBC_WS_ZERO = 4'h0;
   localparam logic [3:0] ATBC_WS_RESET = 4'h0;
   // test-mode hazard limit on the wait-select straps
   localparam int ATBC_TEST_MODE_NS = 60;
   localparam int ATBC_CLK_PERIOD_NS = 5;
   localparam logic [4:0] ATBC_TEST_MODE_CYC =
      5'(ATBC_TEST_MODE_NS / ATBC_CLK_PERIOD_NS);
   localparam logic [1:0] ATBC_DELAY_CYC = 2'h1;

   // slot command group, all active low
   typedef struct packed {
      logic memr_n;
      logic memw_n;
      logic ior_n;
      logic iow_n;
   } atbc_cmd_t;

   // low-megabyte memory strobes
   typedef struct packed {
      logic memr_n;
      logic memw_n;
   } atbc_smem_t;

   // cycle request from the processor side
   typedef struct packed {
      logic start;      // one-cycle pulse opening a slot cycle
      logic is_write;   // write when set
      logic is_mem;     // memory cycle when set, i/o when clear
      logic convert;    // 16-to-8 bit conversion, two halves
   } atbc_req_t;

   typedef enum logic [2:0] {
      ATBC_IDLE  = 3'b000,
      ATBC_DELAY = 3'b001,
      ATBC_WAIT  = 3'b011,
      ATBC_LAST  = 3'b010,
      ATBC_GAP   = 3'b110
   } atbc_state_t;

   localparam atbc_cmd_t ATBC_CMD_IDLE = 4'hF;

endpackage : atbc_pkg

// >>> rtl/atbc_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a bundle of pin inputs
module atbc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         CORE_CLK,   // processor clock
   input  wire logic         RST_N,      // synchronous reset
   input  wire logic [W-1:0] D,          // asynchronous input
   output logic      [W-1:0] Q           // synchronised output
);
   logic [W-1:0] meta_reg;

   // first stage is read by the second stage only
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         meta_reg <= INIT;
         Q        <= INIT;
      end
      else
      begin
         meta_reg <= D;
         Q        <= meta_reg;
      end
   end
endmodule : atbc_sync

// >>> rtl/atbc_bus_cycle.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module atbc_bus_cycle
   import atbc_pkg::*;
(
   input  wire logic             CORE_CLK,        // processor clock
   input  wire logic             RST_N,           // sync reset, low
   input  atbc_pkg::atbc_req_t   CYCLE_REQ,       // processor request
   output logic                  CYCLE_DONE,      // cycle end pulse
   input  wire logic             IOCHRDY,         // slot channel ready
   input  wire logic             ZERO_WAIT_REQUEST_N, // slot zero-wait
   input  wire logic             MEM_CS16_N,      // slot mem 16-bit
   input  wire logic             IO_CS16_N,       // slot i/o 16-bit
   input  wire logic             SIXTEEN_BIT_MEMORY_FLAG, // width hint
   input  wire logic             RAM_READ_WAIT_SELECT,  // strap
   input  wire logic             RAM_WRITE_WAIT_SELECT, // strap
   output logic                  TEST_MODE_HAZARD,  // strap misuse seen
   input  wire logic             DMA8_ADDRESS_ENABLE_N,  // 8-bit dma
   input  wire logic             DMA16_ADDRESS_ENABLE_N, // 16-bit dma
   output logic                  DMA_ADDRESS_ENABLE_OUT_N, // dma aen
   input  wire logic             BUS_MASTER_MODE, // external master
   input  wire logic             SA0,             // slot addr bit 0
   input  wire logic             CPU_BYTE_HIGH_N, // cpu high byte
   output logic                  EXPANSION_BYTE_HIGH_ENABLE_N, // sbhe
   input  atbc_pkg::atbc_cmd_t   SLOT_CMD_IN_N,   // master strobes
   output atbc_pkg::atbc_cmd_t   SLOT_CMD_OUT_N,  // slot strobes
   output logic                  SLOT_CMD_OE,     // slot strobe drive
   input  atbc_pkg::atbc_cmd_t   PERIPHERAL_BUS_COMMANDS_IN_N, // x in
   output atbc_pkg::atbc_cmd_t   PERIPHERAL_BUS_COMMANDS_N, // x out
   output logic                  PERIPHERAL_CMD_OE, // x strobe drive
   output atbc_pkg::atbc_smem_t  LOW_MEG_MEMORY_COMMANDS_N, // smem
   input  wire logic             PERIPHERAL_ADDR_BIT9, // x addr 9
   input  wire logic             PERIPHERAL_ADDR_BIT8, // x addr 8
   input  wire logic             COPROCESSOR_SELECT_N, // npx select
   output logic                  XBUS_DATA_DIRECTION, // x data dir
   output logic                  LOW_BYTE_BUFFER_ENABLE_N,  // low lane
   output logic                  HIGH_BYTE_BUFFER_ENABLE_N, // high lane
   output logic                  SWAP_BUFFER_DIRECTION, // swap dir
   output logic                  CONVERSION_LATCH_OFF // hold data
);
   import atbc_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [5:0] pin_sync;
   logic       rdy_s;
   logic       zws_n_s;
   logic       mcs16_n_s;
   logic       iocs16_n_s;
   logic       rd_ws_s;
   logic       wr_ws_s;

   atbc_sync #(.W(6), .INIT(6'h3D)) u_sync (
      .CORE_CLK (CORE_CLK),
      .RST_N    (RST_N),
      .D        ({IOCHRDY, ZERO_WAIT_REQUEST_N, MEM_CS16_N, IO_CS16_N,
                  RAM_READ_WAIT_SELECT, RAM_WRITE_WAIT_SELECT}),
      .Q        (pin_sync)
   );
   assign {rdy_s, zws_n_s, mcs16_n_s, iocs16_n_s, rd_ws_s, wr_ws_s} =
      pin_sync;

   //////////////////////////////////////////////////////////////////////////
   // mode decode
   logic dma_mode;
   logic cyc_mode;

   // no clock on the enable path so it tracks the dma controller
   assign DMA_ADDRESS_ENABLE_OUT_N =
      DMA8_ADDRESS_ENABLE_N & DMA16_ADDRESS_ENABLE_N;
   assign dma_mode = ~DMA_ADDRESS_ENABLE_OUT_N;
   assign cyc_mode = ~dma_mode & ~BUS_MASTER_MODE;

   //////////////////////////////////////////////////////////////////////////
   // sequencer state
   atbc_state_t state_reg;
   atbc_state_t state_next;
   logic [3:0]  ws_cnt_reg;
   logic        wide_reg;
   logic        write_reg;
   logic        mem_reg;
   logic        conv_reg;
   logic        half2_reg;
   logic        rdy_seen_reg;

   // ready is judged on the synchronised level, so sampling points sit
   // two clocks behind the pin; slots must hold ready accordingly
   function automatic logic ws_done(input logic [3:0] cnt,
                                    input logic       wide,
                                    input logic       rdy,
                                    input logic       seen);
      if (wide)
         ws_done = seen | (rdy && cnt >= ATBC_WS_16BIT_MIN);
      else
         ws_done = seen | (rdy && cnt >= ATBC_WS_8BIT_FIRST);
   endfunction : ws_done

   // width of the cycle from the slot's chip-select answer
   function automatic logic is_wide(input logic mem,
                                    input logic mcs_n,
                                    input logic iocs_n);
      // i/o width follows its own select, never the memory hint
      is_wide = mem ? ~mcs_n : ~iocs_n;
   endfunction : is_wide

   // next-state decode
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ATBC_IDLE:
            if (CYCLE_REQ.start && cyc_mode)
               state_next = is_wide(CYCLE_REQ.is_mem, mcs16_n_s,
                                    iocs16_n_s) ? ATBC_WAIT
                                                : ATBC_DELAY;
         ATBC_DELAY:
            state_next = ATBC_WAIT;
         ATBC_WAIT:
            if (wide_reg && mem_reg && !zws_n_s)
               state_next = ATBC_LAST;
            else if (ws_done(ws_cnt_reg, wide_reg, rdy_s, rdy_seen_reg))
               state_next = ATBC_LAST;
         ATBC_LAST:
            state_next = (conv_reg && !half2_reg) ? ATBC_GAP : ATBC_IDLE;
         ATBC_GAP:
            state_next = ATBC_DELAY;
         default:
            state_next = ATBC_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         state_reg <= ATBC_IDLE;
      else
         state_reg <= state_next;
   end

   // cycle attributes captured at the start
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         wide_reg  <= 1'b0;
         write_reg <= 1'b0;
         mem_reg   <= 1'b0;
         conv_reg  <= 1'b0;
      end
      else if (state_reg == ATBC_IDLE && CYCLE_REQ.start && cyc_mode)
      begin
         wide_reg  <= is_wide(CYCLE_REQ.is_mem, mcs16_n_s, iocs16_n_s);
         write_reg <= CYCLE_REQ.is_write;
         mem_reg   <= CYCLE_REQ.is_mem;
         conv_reg  <= CYCLE_REQ.convert;
      end
   end

   // wait-state count and ready latch; a seen ready ends one wait later
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || state_reg != ATBC_WAIT)
      begin
         ws_cnt_reg   <= ATBC_WS_RESET;
         rdy_seen_reg <= 1'b0;
      end
      else
      begin
         ws_cnt_reg   <= (ws_cnt_reg == 4'hF) ? ws_cnt_reg
                                              : ws_cnt_reg + 4'h1;
         rdy_seen_reg <= rdy_s && (wide_reg ||
                         ws_cnt_reg >= ATBC_WS_8BIT_FIRST);
      end
   end

   // second half of a conversion
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || state_reg == ATBC_IDLE)
         half2_reg <= 1'b0;
      else if (state_reg == ATBC_GAP)
         half2_reg <= 1'b1;
   end

   assign CYCLE_DONE = (state_reg == ATBC_LAST) &&
                       !(conv_reg && !half2_reg);

   //////////////////////////////////////////////////////////////////////////
   // byte-lane buffer enables
   logic active;
   logic den_raw_reg;
   logic den_dly_reg;
   logic den_on;
   logic low_off;

   assign active = (state_reg == ATBC_DELAY) || (state_reg == ATBC_WAIT) ||
                   (state_reg == ATBC_LAST);

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         den_raw_reg <= 1'b0;
         den_dly_reg <= 1'b0;
      end
      else
      begin
         den_raw_reg <= active;
         den_dly_reg <= den_raw_reg;
      end
   end

   // reads open late and close early; writes the other way round
   assign den_on = write_reg ? (den_raw_reg | den_dly_reg)
                             : (den_raw_reg & den_dly_reg);
   assign low_off = conv_reg && half2_reg && write_reg;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         LOW_BYTE_BUFFER_ENABLE_N  <= 1'b1;
         HIGH_BYTE_BUFFER_ENABLE_N <= 1'b1;
         SWAP_BUFFER_DIRECTION     <= 1'b1;
         CONVERSION_LATCH_OFF      <= 1'b0;
      end
      else if (cyc_mode)
      begin
         LOW_BYTE_BUFFER_ENABLE_N  <= ~(den_on & ~low_off);
         HIGH_BYTE_BUFFER_ENABLE_N <= ~den_on;
         SWAP_BUFFER_DIRECTION     <= ~write_reg | ~active;
         CONVERSION_LATCH_OFF      <= conv_reg & half2_reg;
      end
      else
      begin
         // dma and master: lanes follow address and byte-high strobe
         LOW_BYTE_BUFFER_ENABLE_N  <= SA0;
         HIGH_BYTE_BUFFER_ENABLE_N <= EXPANSION_BYTE_HIGH_ENABLE_N;
         SWAP_BUFFER_DIRECTION     <= PERIPHERAL_BUS_COMMANDS_IN_N.memw_n;
         CONVERSION_LATCH_OFF      <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // slot command strobes
   logic      cmd_on;
   atbc_cmd_t cyc_cmd;

   // 8-bit cycles spend a delay state before the strobe drops
   assign cmd_on = (state_reg == ATBC_WAIT) || (state_reg == ATBC_LAST);
   always_comb
   begin
      cyc_cmd        = ATBC_CMD_IDLE;
      cyc_cmd.memr_n = ~(cmd_on & mem_reg & ~write_reg);
      cyc_cmd.memw_n = ~(cmd_on & mem_reg & write_reg);
      cyc_cmd.ior_n  = ~(cmd_on & ~mem_reg & ~write_reg);
      cyc_cmd.iow_n  = ~(cmd_on & ~mem_reg & write_reg);
   end

   // strobe routing per mode, registered for clean edges
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         SLOT_CMD_OUT_N            <= ATBC_CMD_IDLE;
         PERIPHERAL_BUS_COMMANDS_N <= ATBC_CMD_IDLE;
         LOW_MEG_MEMORY_COMMANDS_N <= 2'h3;
      end
      else if (dma_mode)
      begin
         SLOT_CMD_OUT_N <= PERIPHERAL_BUS_COMMANDS_IN_N;
         PERIPHERAL_BUS_COMMANDS_N <= ATBC_CMD_IDLE;
         LOW_MEG_MEMORY_COMMANDS_N <=
            {PERIPHERAL_BUS_COMMANDS_IN_N.memr_n,
             PERIPHERAL_BUS_COMMANDS_IN_N.memw_n};
      end
      else if (BUS_MASTER_MODE)
      begin
         SLOT_CMD_OUT_N            <= ATBC_CMD_IDLE;
         PERIPHERAL_BUS_COMMANDS_N <= SLOT_CMD_IN_N;
         LOW_MEG_MEMORY_COMMANDS_N <= {SLOT_CMD_IN_N.memr_n,
                                       SLOT_CMD_IN_N.memw_n};
      end
      else
      begin
         SLOT_CMD_OUT_N            <= cyc_cmd;
         PERIPHERAL_BUS_COMMANDS_N <= cyc_cmd;
         LOW_MEG_MEMORY_COMMANDS_N <= {cyc_cmd.memr_n, cyc_cmd.memw_n};
      end
   end

   // the master owns the slot strobes; dma owns the peripheral ones
   assign SLOT_CMD_OE       = ~BUS_MASTER_MODE;
   assign PERIPHERAL_CMD_OE = ~dma_mode;

   //////////////////////////////////////////////////////////////////////////
   // high byte enable and peripheral data direction
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         EXPANSION_BYTE_HIGH_ENABLE_N <= 1'b1;
      else if (!DMA16_ADDRESS_ENABLE_N)
         EXPANSION_BYTE_HIGH_ENABLE_N <= 1'b0;
      else if (!DMA8_ADDRESS_ENABLE_N)
         EXPANSION_BYTE_HIGH_ENABLE_N <= ~SA0;
      else
         EXPANSION_BYTE_HIGH_ENABLE_N <= CPU_BYTE_HIGH_N;
   end

   // in master mode only a local i/o read away from the coprocessor turns the bus in
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
         XBUS_DATA_DIRECTION <= 1'b1;
      else if (BUS_MASTER_MODE)
         XBUS_DATA_DIRECTION <= ~(~SLOT_CMD_IN_N.ior_n &
                                  ~PERIPHERAL_ADDR_BIT9 &
                                  ~PERIPHERAL_ADDR_BIT8 &
                                  COPROCESSOR_SELECT_N);
      else if (dma_mode)
         XBUS_DATA_DIRECTION <= PERIPHERAL_BUS_COMMANDS_IN_N.ior_n;
      else
         XBUS_DATA_DIRECTION <= ~(cmd_on & ~write_reg);
   end

   //////////////////////////////////////////////////////////////////////////
   // wait-select strap misuse watch; flags but cannot prevent it
   logic [4:0] haz_cnt_reg;

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || !(rd_ws_s && !wr_ws_s))
         haz_cnt_reg <= 5'h00;
      else if (haz_cnt_reg != ATBC_TEST_MODE_CYC)
         haz_cnt_reg <= haz_cnt_reg + 5'h01;
   end

   assign TEST_MODE_HAZARD = (haz_cnt_reg == ATBC_TEST_MODE_CYC);

endmodule : atbc_bus_cycle

// >>> bench/atbc_props.sv
`timescale 1ns/10ps
// pin-level checker for the slot cycle sequencer
module atbc_props
   import atbc_pkg::*;
(
   input wire logic           CORE_CLK,      // processor clock
   input wire logic           RST_N,         // sync reset
   input atbc_pkg::atbc_req_t CYCLE_REQ,     // request
   input wire logic           CYCLE_DONE,    // cycle end
   input wire logic           RAM_READ_WAIT_SELECT,   // strap
   input wire logic           RAM_WRITE_WAIT_SELECT,  // strap
   input wire logic           TEST_MODE_HAZARD,       // misuse
   input wire logic           DMA8_ADDRESS_ENABLE_N,  // dma 8
   input wire logic           DMA16_ADDRESS_ENABLE_N, // dma 16
   input wire logic           DMA_ADDRESS_ENABLE_OUT_N, // dma out
   input wire logic           BUS_MASTER_MODE, // master
   input wire logic           SA0,           // slot addr 0
   input wire logic           EXPANSION_BYTE_HIGH_ENABLE_N, // hi
   input atbc_pkg::atbc_cmd_t SLOT_CMD_IN_N,  // master strobes
   input atbc_pkg::atbc_cmd_t SLOT_CMD_OUT_N, // slot strobes
   input atbc_pkg::atbc_cmd_t PERIPHERAL_BUS_COMMANDS_IN_N, // x in
   input atbc_pkg::atbc_cmd_t PERIPHERAL_BUS_COMMANDS_N,    // x out
   input atbc_pkg::atbc_smem_t LOW_MEG_MEMORY_COMMANDS_N    // smem
);
   logic [4:0] hz_cnt_reg; // raw strap-misuse run, saturating
   //////////////////////////////////////////////////////////////////////
   // raw run length; the design sees it two cycles late via synchronisers
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N || !RAM_READ_WAIT_SELECT || RAM_WRITE_WAIT_SELECT)
         hz_cnt_reg <= 5'h0;
      else if (hz_cnt_reg != 5'h1f)
         hz_cnt_reg <= hz_cnt_reg + 5'h1;
   end
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   chk_aen_follows: assert property (
      DMA_ADDRESS_ENABLE_OUT_N ==
      (DMA8_ADDRESS_ENABLE_N & DMA16_ADDRESS_ENABLE_N))
      else $error("dma enable out wrong");
   chk_hibyte_dma16: assert property (
      $past(RST_N) && !$past(DMA16_ADDRESS_ENABLE_N)
      |-> !EXPANSION_BYTE_HIGH_ENABLE_N) else $error("hi byte not low");
   chk_hibyte_dma8: assert property (
      $past(RST_N) && $past(DMA16_ADDRESS_ENABLE_N)
      && !$past(DMA8_ADDRESS_ENABLE_N)
      |-> EXPANSION_BYTE_HIGH_ENABLE_N == !$past(SA0))
      else $error("hi byte not inverse of sa0");
   chk_dma_cmds: assert property (
      $past(RST_N) && !$past(DMA_ADDRESS_ENABLE_OUT_N)
      |-> SLOT_CMD_OUT_N == $past(PERIPHERAL_BUS_COMMANDS_IN_N)
      && LOW_MEG_MEMORY_COMMANDS_N ==
      $past(PERIPHERAL_BUS_COMMANDS_IN_N[3:2]))
      else $error("dma strobes wrong");
   chk_master_cmds: assert property (
      $past(RST_N) && $past(BUS_MASTER_MODE)
      |-> PERIPHERAL_BUS_COMMANDS_N == $past(SLOT_CMD_IN_N))
      else $error("master strobes wrong");
   chk_done_single: assert property (
      CYCLE_DONE |=> !CYCLE_DONE) else $error("done held");
   chk_done_late: assert property (
      CYCLE_DONE |-> !$past(CYCLE_REQ.start)) else $error("no wait");
   chk_hazard_early: assert property (
      TEST_MODE_HAZARD |-> $past(hz_cnt_reg, 2) >= ATBC_TEST_MODE_CYC)
      else $error("hazard too early");
   chk_hazard_late: assert property (
      hz_cnt_reg == ATBC_TEST_MODE_CYC + 5'h02 |-> TEST_MODE_HAZARD)
      else $error("hazard missed");
endmodule : atbc_props

bind atbc_bus_cycle atbc_props i_atbc_props (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CYCLE_REQ(CYCLE_REQ),
   .CYCLE_DONE(CYCLE_DONE), .RAM_READ_WAIT_SELECT(RAM_READ_WAIT_SELECT),
   .RAM_WRITE_WAIT_SELECT(RAM_WRITE_WAIT_SELECT),
   .TEST_MODE_HAZARD(TEST_MODE_HAZARD), .SA0(SA0),
   .DMA8_ADDRESS_ENABLE_N(DMA8_ADDRESS_ENABLE_N),
   .DMA16_ADDRESS_ENABLE_N(DMA16_ADDRESS_ENABLE_N),
   .DMA_ADDRESS_ENABLE_OUT_N(DMA_ADDRESS_ENABLE_OUT_N),
   .BUS_MASTER_MODE(BUS_MASTER_MODE), .SLOT_CMD_IN_N(SLOT_CMD_IN_N),
   .EXPANSION_BYTE_HIGH_ENABLE_N(EXPANSION_BYTE_HIGH_ENABLE_N),
   .SLOT_CMD_OUT_N(SLOT_CMD_OUT_N),
   .PERIPHERAL_BUS_COMMANDS_IN_N(PERIPHERAL_BUS_COMMANDS_IN_N),
   .PERIPHERAL_BUS_COMMANDS_N(PERIPHERAL_BUS_COMMANDS_N),
   .LOW_MEG_MEMORY_COMMANDS_N(LOW_MEG_MEMORY_COMMANDS_N));

// >>> bench/atbc_slot_card.sv
`timescale 1ns/10ps
// behavioural expansion card answering the slot strobes
module atbc_slot_card
   import atbc_pkg::*;
(
   input wire logic           clk,      // processor clock
   input atbc_pkg::atbc_cmd_t cmd_n,    // slot strobes
   input wire logic           wide,     // answer as 16-bit card
   input wire logic           zws,      // ask for zero waits
   input int                  stall,    // ready held low this long
   output logic               rdy,      // channel ready
   output logic               zws_n,    // zero-wait request
   output logic               mcs16_n,  // memory 16-bit answer
   output logic               iocs16_n  // i/o 16-bit answer
);
   int cnt_reg = 0; // strobe-active cycles so far
   //////////////////////////////////////////////////////////////////////
   // ready is pulled low ahead of the strobe, else the first sample misses
   always_ff @(posedge clk)
   begin
      if (cmd_n == ATBC_CMD_IDLE)
         cnt_reg <= 0;
      else
         cnt_reg <= cnt_reg + 1;
   end
   assign rdy = (cnt_reg >= stall);
   // zero-wait is only legal from a 16-bit card
   assign zws_n = !(zws && wide);
   assign mcs16_n = !wide;
   assign iocs16_n = !wide;
endmodule : atbc_slot_card

// >>> bench/at_bus_cycle_control_tb_top.sv
`timescale 1ns/10ps
// bench: slot cycles against a card model, then dma, master and straps
module at_bus_cycle_control_tb_top;
   import atbc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0;
   atbc_req_t   req = '0;
   logic        rdy, zws_n, mcs_n, iocs_n, swap_d;
   logic        f16 = 1'b0, rdw = 1'b0, wrw = 1'b1, bhe_n = 1'b0;
   logic        d8 = 1'b1, d16 = 1'b1, mst = 1'b0, wide = 1'b1, zws = 1'b0;
   logic        sa0 = 1'b0, a9 = 1'b1, a8 = 1'b1, coprocessor_select_n = 1'b1;
   atbc_cmd_t   sin = ATBC_CMD_IDLE, pin = ATBC_CMD_IDLE, sout, pout;
   atbc_smem_t  lmeg;
   logic        done, haz, aen, sbhe, soe, poe, xdir, enlo, enhi, swap, lat_o;
   logic [31:0] seed = 32'h603a_b0cb;
   int          stall = 0, num_errors = 0, comparisons = 0, cyc = 0;
   int          lat, en_on, en_off, bad_lo, latch_seen, i, r_on, r_off;
   //////////////////////////////////////////////////////////////////////
   always #2.5 clk = ~clk;
   atbc_bus_cycle i_atbc_bus_cycle (.CORE_CLK(clk), .RST_N(rst_n),
      .CYCLE_REQ(req), .CYCLE_DONE(done), .IOCHRDY(rdy),
      .ZERO_WAIT_REQUEST_N(zws_n), .MEM_CS16_N(mcs_n), .IO_CS16_N(iocs_n),
      .SIXTEEN_BIT_MEMORY_FLAG(f16), .RAM_READ_WAIT_SELECT(rdw),
      .RAM_WRITE_WAIT_SELECT(wrw), .TEST_MODE_HAZARD(haz),
      .DMA8_ADDRESS_ENABLE_N(d8), .DMA16_ADDRESS_ENABLE_N(d16),
      .DMA_ADDRESS_ENABLE_OUT_N(aen), .BUS_MASTER_MODE(mst), .SA0(sa0),
      .CPU_BYTE_HIGH_N(bhe_n), .EXPANSION_BYTE_HIGH_ENABLE_N(sbhe),
      .SLOT_CMD_IN_N(sin), .SLOT_CMD_OUT_N(sout), .SLOT_CMD_OE(soe),
      .PERIPHERAL_BUS_COMMANDS_IN_N(pin), .PERIPHERAL_BUS_COMMANDS_N(pout),
      .PERIPHERAL_CMD_OE(poe), .LOW_MEG_MEMORY_COMMANDS_N(lmeg),
      .PERIPHERAL_ADDR_BIT9(a9), .PERIPHERAL_ADDR_BIT8(a8),
      .COPROCESSOR_SELECT_N(coprocessor_select_n), .XBUS_DATA_DIRECTION(xdir),
      .LOW_BYTE_BUFFER_ENABLE_N(enlo), .HIGH_BYTE_BUFFER_ENABLE_N(enhi),
      .SWAP_BUFFER_DIRECTION(swap), .CONVERSION_LATCH_OFF(lat_o));
   atbc_slot_card i_atbc_slot_card (.clk(clk), .cmd_n(sout), .wide(wide),
      .zws(zws), .stall(stall), .rdy(rdy), .zws_n(zws_n), .mcs16_n(mcs_n),
      .iocs16_n(iocs_n));
   // comparison helpers, one per kind of result
   task automatic chk_bit(input logic got, input logic exp, input string s);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, s);
      end
   endtask : chk_bit
   task automatic chk_cmd(input atbc_cmd_t got, input atbc_cmd_t exp,
                          input string s);
      chk_bit(got === exp, 1'b1, s);
   endtask : chk_cmd
   task automatic chk_num(input int got, input int exp, input string s);
      chk_bit(got == exp, 1'b1, s);
   endtask : chk_num
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   // one slot cycle; settle time first lets the synchronisers catch up
   task automatic run_cyc(input logic w, input logic m, input logic cv);
      int k;
      lat = 0;
      en_on = 0;
      en_off = 0;
      bad_lo = 0;
      latch_seen = 0;
      repeat (3) @(posedge clk);
      req <= '{1'b1, w, m, cv};
      @(posedge clk);
      req <= '0;
      for (k = 1; k < 400 && en_off == 0; k++)
      begin
         @(negedge clk);
         if (en_on == 0 && enlo === 1'b0)
            en_on = k;
         if (lat_o === 1'b1)
            latch_seen = 1;
         if (lat_o === 1'b1 && enlo === 1'b0 && w)
            bad_lo++;
         if (done === 1'b1 && lat == 0)
            swap_d = swap;
         if (done === 1'b1 && lat == 0)
            lat = k;
         else if (lat != 0 && en_on != 0 && enlo === 1'b1)
            en_off = k;
      end
      @(posedge clk);
   endtask : run_cyc
   // hang guard, far above the several hundred cycles the run needs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         num_errors++;
         $display("mismatch at %0t: run hung", $time);
         test_done();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk);
      chk_cmd(sout, ATBC_CMD_IDLE, "slot strobes after reset");
      chk_cmd(atbc_cmd_t'({enlo, enhi, swap, xdir}), 4'hF, "reset levels");
      chk_bit(lat_o | done, 1'b0, "latch or done after reset");
      $display("test reset finished");
      run_cyc(1'b0, 1'b1, 1'b0);
      chk_num(lat, 3, "16-bit read waits");
      chk_bit(swap_d, 1'b1, "swap on read");
      r_on = en_on;
      r_off = en_off - lat;
      run_cyc(1'b1, 1'b1, 1'b0);
      chk_num(lat, 3, "16-bit write waits");
      chk_bit(swap_d, 1'b0, "swap on write");
      chk_num(r_on - en_on, 1, "enable on later for read");
      chk_num(en_off - lat - r_off, 1, "enable off later for write");
      for (i = 0; i < 2; i++)
      begin
         f16 <= i[0];
         run_cyc(i[0], 1'b0, 1'b0);
         chk_num(lat, 3, "i/o like off-board memory");
      end
      $display("test 16-bit finished");
      stall <= 6;
      zws <= 1'b1;
      run_cyc(1'b0, 1'b1, 1'b0);
      chk_bit(lat <= 2, 1'b1, "zero-wait shortens");
      zws <= 1'b0;
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         stall <= 2 + int'(seed[2:0]);
         run_cyc(seed[3], 1'b1, 1'b0);
         chk_bit(lat > stall + 1 && lat < stall + 12, 1'b1, "stall");
      end
      stall <= 0;
      wide <= 1'b0;
      run_cyc(1'b0, 1'b1, 1'b0);
      chk_bit(lat >= 6 && lat <= 10, 1'b1, "8-bit memory");
      run_cyc(1'b1, 1'b0, 1'b0);
      chk_bit(lat >= 6 && lat <= 10, 1'b1, "8-bit i/o delay");
      stall <= 14;
      run_cyc(1'b0, 1'b1, 1'b0);
      chk_bit(lat > 15, 1'b1, "8-bit stretch");
      stall <= 0;
      for (i = 0; i < 2; i++)
      begin
         run_cyc(1'b1, i[0], 1'b1);
         chk_num(latch_seen, 1, "conversion latch");
         chk_num(bad_lo, 0, "low lane in second half");
      end
      wide <= 1'b1;
      $display("test wait states finished");
      for (i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         @(posedge clk);
         d16 <= seed[0] & seed[1];
         d8 <= seed[2];
         sa0 <= seed[3];
         bhe_n <= seed[9];
         pin <= atbc_cmd_t'(seed[7:4]);
         repeat (2) @(negedge clk);
         chk_bit(aen, d8 & d16, "dma enable out");
         chk_bit(poe, aen, "peripheral drive");
         if (!d16)
            chk_bit(sbhe, 1'b0, "hi byte in 16-bit dma");
         else if (!d8)
            chk_bit(sbhe, !sa0, "hi byte in 8-bit dma");
         else
            chk_bit(sbhe, bhe_n, "hi byte from cpu");
         if (!aen)
            chk_cmd(sout, pin, "slot strobes in dma");
         if (!aen)
            chk_bit(lmeg === atbc_smem_t'(pin[3:2]), 1'b1, "low meg");
      end
      @(posedge clk);
      d8 <= 1'b1;
      d16 <= 1'b1;
      pin <= ATBC_CMD_IDLE;
      mst <= 1'b1;
      $display("test dma finished");
      for (i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         @(posedge clk);
         sin <= seed[8] ? atbc_cmd_t'(4'hD) : atbc_cmd_t'(seed[3:0]);
         a9 <= seed[4] & !seed[8];
         a8 <= seed[5] & !seed[8];
         coprocessor_select_n <= seed[6] | seed[8];
         repeat (2) @(negedge clk);
         chk_cmd(pout, sin, "peripheral strobes");
         chk_bit(soe, 1'b0, "slot strobes released");
         chk_bit(xdir, !(!sin.ior_n && !a9 && !a8 && coprocessor_select_n), "xdir");
      end
      @(posedge clk);
      mst <= 1'b0;
      sin <= ATBC_CMD_IDLE;
      $display("test master finished");
      rdw <= 1'b1;
      wrw <= 1'b0;
      repeat (8) @(negedge clk);
      chk_bit(haz, 1'b0, "hazard too soon");
      repeat (14) @(negedge clk);
      chk_bit(haz, 1'b1, "hazard flagged");
      @(posedge clk);
      rdw <= 1'b0;
      wrw <= 1'b1;
      repeat (5) @(negedge clk);
      chk_bit(haz, 1'b0, "hazard cleared");
      $display("test straps finished");
      test_done();
   end
endmodule : at_bus_cycle_control_tb_top
